// *** hdl/cccal_pkg.sv ***
// Constants, field layout and types shared by the calibration control block
package cccal_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TRIM = 8'h59;
  localparam logic [7:0] ADDR_SYNTH_RST = 8'h5C;
  localparam logic [7:0] ADDR_TUNE_CTRL = 8'h5D;
  localparam logic [7:0] ADDR_TUNE_STAT = 8'h5E;
  localparam logic [7:0] ADDR_LINK_EN = 8'h60;
  localparam logic [7:0] ADDR_CAL_ENABLE = 8'h61;
  localparam logic [7:0] ADDR_CAL_CFG = 8'h62;
  localparam logic [7:0] ADDR_CAL_STAT = 8'h6A;

  // Values after reset
  localparam logic [7:0] TUNE_CTRL_RST = 8'h40;
  localparam logic [7:0] CAL_ENABLE_RST = 8'h01;
  localparam logic [7:0] CAL_CFG_RST = 8'h01;
  localparam logic [6:0] TRIM_RST = 7'h00;

  // Field positions
  localparam int TUNE_EN_BIT = 0;
  localparam int SETTLE_LSB = 4;
  localparam int SETTLE_MSB = 6;
  localparam int CAL_ENABLE_BIT = 0;
  localparam int CFG_FG_BIT = 0;
  localparam int CFG_BG_BIT = 1;
  localparam int CFG_OS_BIT = 2;
  localparam int CFG_BGOS_BIT = 3;

  // Trim search
  localparam int TRIM_W = 7;
  localparam logic [6:0] TRIM_MID = 7'h40;
  localparam logic [2:0] TRIM_TOP_BIT = 3'h6;

  // Cycle counts
  localparam logic [11:0] SETTLE_BASE_CYCLES = 12'h010;
  localparam int FG_CAL_CYCLES = 1024;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cccal_reg_req_t;

  typedef struct packed {
    logic fgRun;
    logic fgOffsetRun;
    logic bgRun;
    logic bgOffsetRun;
  } cccal_cal_run_t;

  typedef enum logic [3:0] {
    TUNE_IDLE = 4'b0001,
    TUNE_SETTLE = 4'b0010,
    TUNE_DECIDE = 4'b0100,
    TUNE_DONE = 4'b1000
  } cccal_tune_state_t;

  typedef enum logic [3:0] {
    CAL_HOLD = 4'b0001,
    CAL_CLEAR = 4'b0010,
    CAL_FORE = 4'b0100,
    CAL_RUN = 4'b1000
  } cccal_cal_state_t;

endpackage

// *** hdl/cccal_top.sv ***
// Register bank and sequencing for oscillator tuning and core calibration
// Summary of operation
// - Settling code bits 6:4, reset 4, sets wait per trim step; larger is longer.
// - With tuning enabled, the run starts when synthesizer reset returns to 0.
// - During a run the engine searches the trim value to centre the oscillator.
// - Done bit 0 reads 1 after a run, or at once when tuning is skipped.
// - Calibration enable 1 runs calibration; 0 holds it in reset.
// - Clearing calibration enable also resets the processing and link clock dividers.
// - Bit 3 enables background offset calibration, only together with background.
// - Bit 2 enables foreground offset calibration, only together with foreground.
// - Bit 1 enables background calibration; 0 after reset disables it.
// - A run first clears calibration values, then foreground runs if bit 0 set.
// - Foreground done flag reads high once foreground completes or is skipped.
`timescale 1ns/1ns
`default_nettype none

module cccal_top #(
  parameter int FG_CYCLES = cccal_pkg::FG_CAL_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire cccal_pkg::cccal_reg_req_t regReq,
  input wire logic vcoTooFast,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic synthResetOut,
  output logic [6:0] oscTrim,
  output logic tuneDone,
  output logic calCoreReset,
  output logic dividerReset,
  output logic calValuesClear,
  output cccal_pkg::cccal_cal_run_t calRun,
  output logic foregroundDoneFlag,
  output logic serialLinkEnable
);

  // Register storage
  logic [7:0] tuneCtrl_q, tuneCtrl_d;
  logic synthReset_q, synthReset_d;
  logic calEnable_q, calEnable_d;
  logic [3:0] calCfg_q, calCfg_d;
  logic linkEnable_q, linkEnable_d;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q, rdValid_d;
  logic trimLoad;
  logic [6:0] trimValue;
  logic tunerDone;

  // Core calibration sequencer
  cccal_pkg::cccal_cal_state_t calState_q, calState_d;
  logic [15:0] fgCnt_q, fgCnt_d;
  logic foregroundDone_q, foregroundDone_d;
  logic coreReset_q, coreReset_d;
  logic divReset_q, divReset_d;
  logic valuesClear_q, valuesClear_d;
  cccal_pkg::cccal_cal_run_t run_q, run_d;
  logic cfgFg;
  logic cfgBg;
  logic cfgOs;
  logic cfgBgos;

  // Address match used by the write path and the trim load; reads decode with a case
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  assign trimLoad = regReq.wr && hit(regReq.addr, cccal_pkg::ADDR_TRIM);
  assign cfgFg = calCfg_q[cccal_pkg::CFG_FG_BIT];
  assign cfgBg = calCfg_q[cccal_pkg::CFG_BG_BIT];
  assign cfgOs = calCfg_q[cccal_pkg::CFG_OS_BIT];
  assign cfgBgos = calCfg_q[cccal_pkg::CFG_BGOS_BIT];

  // Register writes; reserved bits are not stored and read back as zero
  always_comb begin
    tuneCtrl_d = tuneCtrl_q;
    synthReset_d = synthReset_q;
    calEnable_d = calEnable_q;
    calCfg_d = calCfg_q;
    linkEnable_d = linkEnable_q;
    if (regReq.wr) begin
      if (hit(regReq.addr, cccal_pkg::ADDR_TUNE_CTRL)) begin
        tuneCtrl_d = 8'h00;
        tuneCtrl_d[cccal_pkg::SETTLE_MSB:cccal_pkg::SETTLE_LSB] =
          regReq.wdata[cccal_pkg::SETTLE_MSB:cccal_pkg::SETTLE_LSB];
        tuneCtrl_d[cccal_pkg::TUNE_EN_BIT] = regReq.wdata[cccal_pkg::TUNE_EN_BIT];
      end
      if (hit(regReq.addr, cccal_pkg::ADDR_SYNTH_RST)) begin
        synthReset_d = regReq.wdata[0];
      end
      if (hit(regReq.addr, cccal_pkg::ADDR_CAL_ENABLE)) begin
        calEnable_d = regReq.wdata[cccal_pkg::CAL_ENABLE_BIT];
      end
      if (hit(regReq.addr, cccal_pkg::ADDR_CAL_CFG)) begin
        calCfg_d = regReq.wdata[3:0];
      end
      if (hit(regReq.addr, cccal_pkg::ADDR_LINK_EN)) begin
        linkEnable_d = regReq.wdata[0];
      end
    end
  end

  // Registered read port; unmapped addresses return zero
  always_comb begin
    rdData_d = rdData_q;
    rdValid_d = regReq.rd;
    if (regReq.rd) begin
      rdData_d = 8'h00;
      case (regReq.addr)
        cccal_pkg::ADDR_TRIM: rdData_d = {1'b0, trimValue};
        cccal_pkg::ADDR_SYNTH_RST: rdData_d = {7'h00, synthReset_q};
        cccal_pkg::ADDR_TUNE_CTRL: rdData_d = tuneCtrl_q;
        cccal_pkg::ADDR_TUNE_STAT: rdData_d = {7'h00, tunerDone};
        cccal_pkg::ADDR_LINK_EN: rdData_d = {7'h00, linkEnable_q};
        cccal_pkg::ADDR_CAL_ENABLE: rdData_d = {7'h00, calEnable_q};
        cccal_pkg::ADDR_CAL_CFG: rdData_d = {4'h0, calCfg_q};
        cccal_pkg::ADDR_CAL_STAT: rdData_d = {7'h00, foregroundDone_q};
        default: rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tuneCtrl_q <= cccal_pkg::TUNE_CTRL_RST;
      synthReset_q <= 1'b0;
      calEnable_q <= cccal_pkg::CAL_ENABLE_RST[0];
      calCfg_q <= cccal_pkg::CAL_CFG_RST[3:0];
      linkEnable_q <= 1'b0;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      tuneCtrl_q <= tuneCtrl_d;
      synthReset_q <= synthReset_d;
      calEnable_q <= calEnable_d;
      calCfg_q <= calCfg_d;
      linkEnable_q <= linkEnable_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  cccal_vco_tuner u_tuner (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .synthReset(synthReset_q),
    .tuneEnable(tuneCtrl_q[cccal_pkg::TUNE_EN_BIT]),
    .settleCode(tuneCtrl_q[cccal_pkg::SETTLE_MSB:cccal_pkg::SETTLE_LSB]),
    .vcoTooFast(vcoTooFast),
    .trimLoad(trimLoad),
    .trimLoadValue(regReq.wdata[6:0]),
    .trimValue(trimValue),
    .tuneDone(tunerDone)
  );

  // Calibration sequence: hold, clear values, optional foreground, then run
  always_comb begin
    calState_d = calState_q;
    fgCnt_d = fgCnt_q;
    foregroundDone_d = foregroundDone_q;
    case (calState_q)
      cccal_pkg::CAL_HOLD: begin
        foregroundDone_d = 1'b0;
        if (calEnable_q) begin
          calState_d = cccal_pkg::CAL_CLEAR;
        end
      end
      cccal_pkg::CAL_CLEAR: begin
        if (cfgFg) begin
          fgCnt_d = 16'(FG_CYCLES - 1);
          calState_d = cccal_pkg::CAL_FORE;
        end else begin
          foregroundDone_d = 1'b1;
          calState_d = cccal_pkg::CAL_RUN;
        end
      end
      cccal_pkg::CAL_FORE: begin
        if (fgCnt_q == 16'h0000) begin
          foregroundDone_d = 1'b1;
          calState_d = cccal_pkg::CAL_RUN;
        end else begin
          fgCnt_d = fgCnt_q - 16'h0001;
        end
      end
      cccal_pkg::CAL_RUN: begin
        calState_d = cccal_pkg::CAL_RUN;
      end
      default: begin
        calState_d = cccal_pkg::CAL_HOLD;
      end
    endcase
    if (!calEnable_q) begin
      calState_d = cccal_pkg::CAL_HOLD;
      foregroundDone_d = 1'b0;
    end
  end

  // Outputs are registered from the next state so they line up with it
  always_comb begin
    coreReset_d = (calState_d == cccal_pkg::CAL_HOLD);
    divReset_d = !calEnable_d;
    valuesClear_d = (calState_d == cccal_pkg::CAL_CLEAR);
    run_d.fgRun = (calState_d == cccal_pkg::CAL_FORE);
    run_d.fgOffsetRun = (calState_d == cccal_pkg::CAL_FORE) && cfgOs && cfgFg;
    run_d.bgRun = (calState_d == cccal_pkg::CAL_RUN) && cfgBg;
    run_d.bgOffsetRun = (calState_d == cccal_pkg::CAL_RUN) && cfgBg && cfgBgos;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calState_q <= cccal_pkg::CAL_HOLD;
      fgCnt_q <= 16'h0000;
      foregroundDone_q <= 1'b0;
      coreReset_q <= 1'b1;
      divReset_q <= 1'b0;
      valuesClear_q <= 1'b0;
      run_q <= '0;
    end else begin
      calState_q <= calState_d;
      fgCnt_q <= fgCnt_d;
      foregroundDone_q <= foregroundDone_d;
      coreReset_q <= coreReset_d;
      divReset_q <= divReset_d;
      valuesClear_q <= valuesClear_d;
      run_q <= run_d;
    end
  end

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign synthResetOut = synthReset_q;
  assign oscTrim = trimValue;
  assign tuneDone = tunerDone;
  assign calCoreReset = coreReset_q;
  assign dividerReset = divReset_q;
  assign calValuesClear = valuesClear_q;
  assign calRun = run_q;
  assign foregroundDoneFlag = foregroundDone_q;
  assign serialLinkEnable = linkEnable_q;

  a_hold_in_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !calEnable_q |=> (calCoreReset && calRun == '0 && !foregroundDoneFlag))
    else $error("calibration not held while disabled");

  a_divider_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $fell(calEnable_q) |-> (dividerReset && !$past(dividerReset)))
    else $error("dividers not reset when calibration cleared");

  a_clear_first: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($rose(calEnable_q) && calState_q == cccal_pkg::CAL_HOLD) |=>
      (calValuesClear && !calCoreReset) ##1 !calValuesClear)
    else $error("values not cleared at start of calibration");

  a_fg_skip: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (calState_q == cccal_pkg::CAL_CLEAR && !cfgFg && calEnable_q) |=>
      (foregroundDoneFlag && !calRun.fgRun))
    else $error("foreground skip did not report done");

  a_fg_runs: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($rose(calRun.fgRun) && FG_CYCLES >= 8) |->
      (calRun.fgRun && !foregroundDoneFlag)[*8])
    else $error("foreground calibration ended early");

  a_fg_offset_pair: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    calRun.fgOffsetRun |-> (calRun.fgRun && $past(cfgOs)))
    else $error("foreground offset without foreground");

  a_divider_release: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(calEnable_q) |-> !dividerReset)
    else $error("dividers still in reset after calibration enabled");

  a_foreground_done_flag_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (foregroundDoneFlag && calEnable_q) |=> foregroundDoneFlag)
    else $error("foreground done dropped while enabled");

  a_bg_offset_pair: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    calRun.bgOffsetRun |-> (calRun.bgRun && $past(cfgBgos)))
    else $error("background offset without background");

  a_bg_follows: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (calState_q == cccal_pkg::CAL_RUN && calEnable_q) |=> (calRun.bgRun == $past(cfgBg)))
    else $error("background run does not follow its enable");

  a_status_read: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (regReq.rd && regReq.addr == cccal_pkg::ADDR_TUNE_STAT) |=>
      (regRdValid && regRdData == {7'h00, $past(tunerDone)}))
    else $error("tuning status read mismatch");

endmodule

`default_nettype wire

// *** hdl/cccal_vco_tuner.sv ***
// Oscillator trim search engine with programmable settling wait
`timescale 1ns/1ns
`default_nettype none

module cccal_vco_tuner (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic synthReset,
  input wire logic tuneEnable,
  input wire logic [2:0] settleCode,
  input wire logic vcoTooFast,
  input wire logic trimLoad,
  input wire logic [6:0] trimLoadValue,
  output logic [6:0] trimValue,
  output logic tuneDone
);

  cccal_pkg::cccal_tune_state_t state_q, state_d;
  logic [11:0] waitCnt_q, waitCnt_d;
  logic [2:0] bitIdx_q, bitIdx_d;
  logic [6:0] trim_q, trim_d;
  logic done_q, done_d;
  logic synthResetPrev_q;
  logic startPulse;
  logic [2:0] nextBit;
  logic inSettle;

  // Wait grows by doubling with each step of the code
  function automatic logic [11:0] settleCycles(input logic [2:0] code);
    settleCycles = cccal_pkg::SETTLE_BASE_CYCLES << code;
  endfunction

  assign startPulse = synthResetPrev_q & ~synthReset;
  assign nextBit = bitIdx_q - 3'h1;
  assign inSettle = (state_q == cccal_pkg::TUNE_SETTLE);

  always_comb begin
    state_d = state_q;
    waitCnt_d = waitCnt_q;
    bitIdx_d = bitIdx_q;
    trim_d = trim_q;
    done_d = done_q;
    case (state_q)
      cccal_pkg::TUNE_IDLE: begin
        if (startPulse && tuneEnable) begin
          trim_d = cccal_pkg::TRIM_MID;
          bitIdx_d = cccal_pkg::TRIM_TOP_BIT;
          waitCnt_d = settleCycles(settleCode) - 12'h001;
          state_d = cccal_pkg::TUNE_SETTLE;
        end else if (startPulse) begin
          done_d = 1'b1;
          state_d = cccal_pkg::TUNE_DONE;
        end else if (trimLoad) begin
          trim_d = trimLoadValue;
        end
      end
      cccal_pkg::TUNE_SETTLE: begin
        if (waitCnt_q == 12'h000) begin
          state_d = cccal_pkg::TUNE_DECIDE;
        end else begin
          waitCnt_d = waitCnt_q - 12'h001;
        end
      end
      cccal_pkg::TUNE_DECIDE: begin
        if (vcoTooFast) begin
          trim_d[bitIdx_q] = 1'b0;
        end
        if (bitIdx_q == 3'h0) begin
          done_d = 1'b1;
          state_d = cccal_pkg::TUNE_DONE;
        end else begin
          bitIdx_d = nextBit;
          trim_d[nextBit] = 1'b1;
          waitCnt_d = settleCycles(settleCode) - 12'h001;
          state_d = cccal_pkg::TUNE_SETTLE;
        end
      end
      cccal_pkg::TUNE_DONE: begin
        if (trimLoad) begin
          trim_d = trimLoadValue;
        end
      end
      default: begin
        state_d = cccal_pkg::TUNE_IDLE;
      end
    endcase
    // Synthesizer reset aborts any run and withdraws completion
    if (synthReset) begin
      state_d = cccal_pkg::TUNE_IDLE;
      done_d = 1'b0;
      if (trimLoad) begin
        trim_d = trimLoadValue;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= cccal_pkg::TUNE_IDLE;
      waitCnt_q <= 12'h000;
      bitIdx_q <= 3'h0;
      trim_q <= cccal_pkg::TRIM_RST;
      done_q <= 1'b0;
      synthResetPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      waitCnt_q <= waitCnt_d;
      bitIdx_q <= bitIdx_d;
      trim_q <= trim_d;
      done_q <= done_d;
      synthResetPrev_q <= synthReset;
    end
  end

  assign trimValue = trim_q;
  assign tuneDone = done_q;

  a_settle_code0: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($rose(inSettle) && settleCode == 3'h0 && !synthReset) |->
      (inSettle && !synthReset)[*8] ##1 (inSettle && !synthReset)[*8] ##1 !inSettle)
    else $error("settle wait not sixteen cycles at code zero");

  a_settle_min: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($rose(inSettle) && !synthReset) |-> (inSettle || synthReset)[*8])
    else $error("settle wait shorter than eight cycles");

  a_start_release: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == cccal_pkg::TUNE_IDLE && startPulse && tuneEnable) |=>
      (inSettle && trimValue == cccal_pkg::TRIM_MID))
    else $error("tuning did not start on reset release");

  a_idle_in_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    synthReset |=> (state_q == cccal_pkg::TUNE_IDLE && !tuneDone))
    else $error("tuner active or done while synthesizer in reset");

  a_skip_done: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == cccal_pkg::TUNE_IDLE && startPulse && !tuneEnable) |=> tuneDone)
    else $error("done missing when tuning skipped");

  a_last_step_done: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == cccal_pkg::TUNE_DECIDE && bitIdx_q == 3'h0 && !synthReset) |=> tuneDone)
    else $error("done missing after last trim step");

  a_trim_step: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == cccal_pkg::TUNE_DECIDE && vcoTooFast && !synthReset) |=>
      (trimValue[$past(bitIdx_q)] == 1'b0))
    else $error("trim bit kept although oscillator too fast");

  a_trim_frozen: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (inSettle && !synthReset) |=> $stable(trimValue))
    else $error("trim changed during settling");

endmodule

`default_nettype wire

// *** testbench/cccal_top_tb_top.sv ***
// Self-checking testbench for the calibration control register bank
`timescale 1ns/1ns
`default_nettype none

module cccal_top_tb_top;
  localparam int FGC = 16;
  localparam logic [6:0] TARGET = 7'h2B;

  logic core_clk;
  logic sys_rst;
  cccal_pkg::cccal_reg_req_t regReq;
  logic vcoTooFast;
  logic [7:0] regRdData;
  logic regRdValid;
  logic synthResetOut;
  logic [6:0] oscTrim;
  logic tuneDone;
  logic calCoreReset;
  logic dividerReset;
  logic calValuesClear;
  cccal_pkg::cccal_cal_run_t calRun;
  logic foregroundDoneFlag;
  logic serialLinkEnable;
  int error_cnt;
  int num_checks;
  int cyc0;
  int cyc1;
  logic [3:0] cfgList [6];

  cccal_top #(.FG_CYCLES(FGC)) i_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .regReq(regReq),
    .vcoTooFast(vcoTooFast),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .synthResetOut(synthResetOut),
    .oscTrim(oscTrim),
    .tuneDone(tuneDone),
    .calCoreReset(calCoreReset),
    .dividerReset(dividerReset),
    .calValuesClear(calValuesClear),
    .calRun(calRun),
    .foregroundDoneFlag(foregroundDoneFlag),
    .serialLinkEnable(serialLinkEnable)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Oscillator comparator: too fast whenever the trim is above the target
  always @(negedge core_clk) begin
    vcoTooFast <= (oscTrim > TARGET);
  end

  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    regReq.wr = 1'b1;
    regReq.addr = addr;
    regReq.wdata = data;
    @(negedge core_clk);
    regReq.wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge core_clk);
    regReq.rd = 1'b1;
    regReq.addr = addr;
    @(negedge core_clk);
    regReq.rd = 1'b0;
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, exp);
  endtask

  // Runs one tuning pass with the given settle code and returns its length
  task automatic tune_run(input logic [2:0] code, output int cyc);
    wr_reg(8'h5C, 8'h01);
    wr_reg(8'h5D, {1'b0, code, 4'h1});
    wr_reg(8'h5C, 8'h00);
    cyc = 0;
    repeat (10) @(negedge core_clk);
    chk({7'h00, tuneDone}, 8'h00);
    while (tuneDone !== 1'b1 && cyc < 2000) begin
      @(negedge core_clk);
      cyc++;
    end
    chk({7'h00, tuneDone}, 8'h01);
    chk({1'b0, oscTrim}, {1'b0, TARGET});
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    error_cnt = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    regReq = '0;
    cfgList = '{4'h1, 4'h5, 4'h3, 4'hB, 4'h0, 4'hF};
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({7'h00, calRun.fgRun}, 8'h01);
    chk({6'h00, calCoreReset, dividerReset}, 8'h00);
    rd_chk(8'h5D, 8'h40);
    rd_chk(8'h61, 8'h01);
    rd_chk(8'h62, 8'h01);
    rd_chk(8'h5E, 8'h00);
    rd_chk(8'h70, 8'h00);
    repeat (FGC) @(negedge core_clk);
    chk({7'h00, foregroundDoneFlag}, 8'h01);
    chk({4'h0, calRun}, 8'h00);
    rd_chk(8'h6A, 8'h01);
    wr_reg(8'h61, 8'h00);
    repeat (2) @(negedge core_clk);
    chk({6'h00, calCoreReset, dividerReset}, 8'h03);
    chk({3'h0, calRun, foregroundDoneFlag}, 8'h00);
    foreach (cfgList[i]) begin
      wr_reg(8'h62, {4'h0, cfgList[i]});
      rd_chk(8'h62, {4'h0, cfgList[i]});
      wr_reg(8'h61, 8'h01);
      for (int k = 0; k < 4 && calValuesClear !== 1'b1; k++) @(negedge core_clk);
      chk({6'h00, calValuesClear, dividerReset}, 8'h02);
      @(negedge core_clk);
      chk({7'h00, calRun.fgRun}, {7'h00, cfgList[i][0]});
      chk({7'h00, calRun.fgOffsetRun}, {7'h00, cfgList[i][0] & cfgList[i][2]});
      repeat (FGC + 2) @(negedge core_clk);
      chk({7'h00, foregroundDoneFlag}, 8'h01);
      chk({4'h0, calRun}, {6'h00, cfgList[i][1], cfgList[i][1] & cfgList[i][3]});
      wr_reg(8'h60, 8'h01);
      @(negedge core_clk);
      chk({7'h00, serialLinkEnable}, 8'h01);
      wr_reg(8'h60, 8'h00);
      wr_reg(8'h61, 8'h00);
      repeat (2) @(negedge core_clk);
      chk({6'h00, calCoreReset, dividerReset}, 8'h03);
      chk({4'h0, calRun}, 8'h00);
    end
    wr_reg(8'h5C, 8'h01);
    wr_reg(8'h5D, 8'h00);
    @(negedge core_clk);
    chk({7'h00, synthResetOut}, 8'h01);
    rd_chk(8'h5E, 8'h00);
    wr_reg(8'h5C, 8'h00);
    repeat (3) @(negedge core_clk);
    chk({7'h00, tuneDone}, 8'h01);
    rd_chk(8'h5E, 8'h01);
    wr_reg(8'h5E, 8'hFF);
    rd_chk(8'h5E, 8'h01);
    tune_run(3'h0, cyc0);
    rd_chk(8'h5E, 8'h01);
    rd_chk(8'h59, {1'b0, TARGET});
    tune_run(3'h1, cyc1);
    chk(8'(cyc1 - cyc0), 8'h70);
    wr_reg(8'h5C, 8'h01);
    repeat (2) @(negedge core_clk);
    chk({7'h00, tuneDone}, 8'h00);
    wr_reg(8'h59, 8'h11);
    rd_chk(8'h59, 8'h11);
    complete_run();
  end
endmodule

`default_nettype wire
